// >>> hdl/rsq_rx_fifo_host_readout.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_rx_fifo_host_readout import rsq_pkg::*; #(
	parameter int DATA_AW = 9,
	parameter int STS_AW = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_mac_valid,
	output logic o_mac_ready,
	input wire logic [31:0] i_mac_data,
	input wire logic i_mac_last,
	input wire logic i_mac_busy,
	input wire logic [31:0] i_mac_csum,
	input wire logic [13:0] i_mac_len,
	input wire logic i_mac_filter_fail,
	input wire logic i_mac_bcast,
	input wire logic i_mac_mcast,
	input wire logic i_mac_len_err,
	input wire logic [6:0] i_mac_low,
	output logic o_rx_enable,
	output logic o_receiver_halted_event,
	output logic o_receiver_error_flag
);
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	function automatic logic known(input logic [7:0] a);
		return (a == `RSQ_A_DATA) || (a == `RSQ_A_STS) || (a == `RSQ_A_DPCTL)
			|| (a == `RSQ_A_CFG) || (a == `RSQ_A_COE) || (a == `RSQ_A_MAC)
			|| (a == `RSQ_A_INFO) || (a == `RSQ_A_FLAG);
	endfunction

	// Bus slave state
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, wdat_reg;
	logic [3:0] wstrb_reg;
	logic [7:0] awaddr_reg;
	logic have_aw_reg, have_w_reg;
	logic aw_hs, w_hs, ar_hs, wr_do;

	// Software registers
	logic skip_reg, flush_reg, csum_en_reg, receiver_enable_bit_reg, passbad_reg;
	logic [4:0] ofs_reg;
	logic [31:0] cfg_img, mac_img, dpctl_img, coe_img;
	logic rxe_reg, running_reg, halted_reg, halt_evt_reg;

	// Write side
	rsq_wstate_t ws_reg;
	logic [1:0] shift_reg;
	logic [2:0] pad_reg;
	logic [31:0] carry_reg, csum_reg, sts_word_reg;
	logic drop_reg, mac_ready_reg;

	// FIFO hookups
	logic d_push, d_commit, d_rewind, d_pop, d_empty, d_last_in;
	logic [32:0] d_wdata, d_rdata;
	logic [DATA_AW:0] d_used, d_avail;
	logic s_push, s_pop, s_empty;
	logic [31:0] s_rdata, sts_word;
	logic [STS_AW:0] s_used, s_avail;
	logic mac_hs, host_dpop, host_spop, skip_pop, flush_go;
	logic [31:0] shift_src, shift_out, carry_out;
	logic [4:0] sh_bits;

	assign aw_hs = i_awvalid & awready_reg;
	assign w_hs = i_wvalid & wready_reg;
	assign ar_hs = i_arvalid & arready_reg;
	assign wr_do = have_aw_reg & have_w_reg & !bvalid_reg;
	assign mac_hs = i_mac_valid & mac_ready_reg;
	assign host_dpop = ar_hs && (i_araddr == `RSQ_A_DATA);
	assign host_spop = ar_hs && (i_araddr == `RSQ_A_STS);
	assign skip_pop = skip_reg && !d_empty; // RULE_06
	assign d_pop = skip_pop | host_dpop;
	assign s_pop = host_spop;
	assign flush_go = flush_reg;

	assign cfg_img = {16'h0000, flush_reg, 2'h0, ofs_reg, 8'h00};
	assign mac_img = {15'h0000, passbad_reg, 13'h0000, receiver_enable_bit_reg, 2'h0};
	assign dpctl_img = {skip_reg, 31'h00000000};
	assign coe_img = {31'h00000000, csum_en_reg};

	// AXI4-Lite write channel
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			have_aw_reg <= 1'b0;
			have_w_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdat_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RSQ_RESP_OK;
		end else begin
			if (aw_hs) begin
				awready_reg <= 1'b0;
				have_aw_reg <= 1'b1;
				awaddr_reg <= i_awaddr;
			end
			if (w_hs) begin
				wready_reg <= 1'b0;
				have_w_reg <= 1'b1;
				wdat_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			if (wr_do) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= known(awaddr_reg) ? `RSQ_RESP_OK : `RSQ_RESP_ERR;
			end else if (bvalid_reg && i_bready) begin
				bvalid_reg <= 1'b0;
				have_aw_reg <= 1'b0;
				have_w_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel; data and status ports pop on the address
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RSQ_RESP_OK;
		end else if (ar_hs) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= known(i_araddr) ? `RSQ_RESP_OK : `RSQ_RESP_ERR;
			unique case (i_araddr)
				`RSQ_A_DATA: rdata_reg <= d_empty ? 32'h00000000 : d_rdata[31:0];
				`RSQ_A_STS: rdata_reg <= s_empty ? 32'h00000000 : s_rdata;
				`RSQ_A_DPCTL: rdata_reg <= dpctl_img;
				`RSQ_A_CFG: rdata_reg <= cfg_img;
				`RSQ_A_COE: rdata_reg <= coe_img;
				`RSQ_A_MAC: rdata_reg <= mac_img;
				`RSQ_A_INFO: rdata_reg <= {8'h00, 8'(s_avail), 16'(d_avail)};
				`RSQ_A_FLAG: rdata_reg <= {30'h00000000, halted_reg, rxe_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Control registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ofs_reg <= 5'h00;
			csum_en_reg <= 1'b0;
			receiver_enable_bit_reg <= 1'b0;
			passbad_reg <= 1'b0;
		end else if (wr_do) begin
			unique case (awaddr_reg)
				`RSQ_A_CFG: ofs_reg <= 5'(wmerge(cfg_img, wdat_reg, wstrb_reg) >> `RSQ_B_OFS); // RULE_20
				`RSQ_A_COE: csum_en_reg <= 1'(wmerge(coe_img, wdat_reg, wstrb_reg) >> `RSQ_B_CSUM);
				`RSQ_A_MAC: begin
					receiver_enable_bit_reg <= 1'(wmerge(mac_img, wdat_reg, wstrb_reg) >> `RSQ_B_RECEIVER_ENABLE_BIT);
					passbad_reg <= 1'(wmerge(mac_img, wdat_reg, wstrb_reg) >> `RSQ_B_PASSBAD);
				end
				default: ;
			endcase
		end
	end

	// Skip request: set by software, cleared by flush or when the head packet's last word is discarded
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			skip_reg <= 1'b0;
		else if (flush_go)
			skip_reg <= 1'b0;
		else if (skip_pop && d_rdata[32])
			skip_reg <= 1'b0; // RULE_23
		else if (wr_do && awaddr_reg == `RSQ_A_DPCTL && wstrb_reg[3] && wdat_reg[`RSQ_B_SKIP])
			skip_reg <= 1'b1; // RULE_02
	end

	// Flush request, taken only with the receiver halted
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			flush_reg <= 1'b0;
		else if (flush_reg)
			flush_reg <= 1'b0; // RULE_09
		else if (wr_do && awaddr_reg == `RSQ_A_CFG && wstrb_reg[1] && wdat_reg[`RSQ_B_FLUSH])
			flush_reg <= !running_reg; // RULE_24
	end

	// Receiver run and halt tracking
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			running_reg <= 1'b0;
			halt_evt_reg <= 1'b0;
			halted_reg <= 1'b1;
		end else begin
			running_reg <= receiver_enable_bit_reg | (running_reg & (i_mac_busy | ws_reg != WS_IDLE));
			halt_evt_reg <= running_reg && !receiver_enable_bit_reg && !i_mac_busy && ws_reg == WS_IDLE; // RULE_22
			halted_reg <= !running_reg;
		end
	end

	// Sticky receiver error; a new event wins over the clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			rxe_reg <= 1'b0;
		else if ((host_dpop && d_empty) || (host_spop && s_empty) // RULE_21
			|| (ws_reg == WS_STS && !drop_reg && s_used[STS_AW]))
			rxe_reg <= 1'b1;
		else if (wr_do && awaddr_reg == `RSQ_A_FLAG && wstrb_reg[0] && wdat_reg[`RSQ_B_RXE])
			rxe_reg <= 1'b0;
	end

	// Byte realignment for the start offset
	always_comb begin
		unique case (ws_reg)
			WS_CSUM: shift_src = csum_reg;
			WS_TAIL: shift_src = 32'h00000000;
			default: shift_src = i_mac_data;
		endcase
		sh_bits = {shift_reg, 3'b000};
		shift_out = (shift_src << sh_bits) | carry_reg;
		carry_out = (shift_reg == 2'h0) ? 32'h00000000 : shift_src >> (6'd32 - {1'b0, sh_bits});
	end

	always_comb begin
		d_push = 1'b0;
		d_last_in = 1'b0;
		unique case (ws_reg)
			WS_PAD: d_push = !d_used[DATA_AW]; // RULE_20
			WS_DATA: begin
				d_push = mac_hs;
				d_last_in = i_mac_last && !csum_en_reg && shift_reg == 2'h0;
			end
			WS_CSUM: begin
				d_push = !d_used[DATA_AW]; // RULE_10
				d_last_in = shift_reg == 2'h0;
			end
			WS_TAIL: begin
				d_push = !d_used[DATA_AW];
				d_last_in = 1'b1;
			end
			default: ;
		endcase
		d_wdata = {d_last_in, (ws_reg == WS_PAD) ? 32'h00000000 : shift_out};
		s_push = ws_reg == WS_STS && !drop_reg && !s_used[STS_AW];
		d_commit = s_push;
		d_rewind = ws_reg == WS_STS && !s_push; // RULE_17
	end

	// Write-side sequencer from the MAC into both FIFOs
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ws_reg <= WS_IDLE;
			shift_reg <= 2'h0;
			pad_reg <= 3'h0;
			carry_reg <= 32'h00000000;
			csum_reg <= 32'h00000000;
			sts_word_reg <= 32'h00000000;
			drop_reg <= 1'b0;
		end else if (flush_go) begin
			ws_reg <= WS_IDLE;
			carry_reg <= 32'h00000000;
		end else begin
			if (d_push)
				carry_reg <= carry_out;
			unique case (ws_reg)
				WS_IDLE: if (i_mac_valid) begin
					shift_reg <= ofs_reg[1:0];
					pad_reg <= ofs_reg[4:2];
					carry_reg <= 32'h00000000;
					ws_reg <= (ofs_reg[4:2] != 3'h0) ? WS_PAD : WS_DATA;
				end
				WS_PAD: if (d_push) begin
					pad_reg <= pad_reg - 3'h1;
					if (pad_reg == 3'h1)
						ws_reg <= WS_DATA;
				end
				WS_DATA: if (mac_hs && i_mac_last) begin
					csum_reg <= i_mac_csum;
					sts_word_reg <= sts_word;
					drop_reg <= (i_mac_len < `RSQ_MIN_FRAME) && !passbad_reg; // RULE_17
					if (csum_en_reg)
						ws_reg <= WS_CSUM;
					else
						ws_reg <= (shift_reg != 2'h0) ? WS_TAIL : WS_STS;
				end
				WS_CSUM: if (d_push)
					ws_reg <= (shift_reg != 2'h0) ? WS_TAIL : WS_STS;
				WS_TAIL: if (d_push)
					ws_reg <= WS_STS;
				WS_STS: ws_reg <= WS_IDLE;
			endcase
		end
	end

	// Registered ready with two words of margin
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			mac_ready_reg <= 1'b0;
		else
			mac_ready_reg <= ws_reg == WS_DATA && !(mac_hs && i_mac_last) && !flush_go
				&& (d_used < (DATA_AW + 1)'(2**DATA_AW - 2));
	end

	rsq_sts_pack u_pack (
		.i_len(i_mac_len),
		.i_filter_fail(i_mac_filter_fail),
		.i_bcast(i_mac_bcast),
		.i_mcast(i_mac_mcast),
		.i_len_err(i_mac_len_err),
		.i_low(i_mac_low),
		.o_word(sts_word)
	);

	// Data FIFO carries an end-of-packet flag beside each word
	rsq_fifo #(.W(33), .AW(DATA_AW)) u_dfifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_flush(flush_go), // RULE_07
		.i_push(d_push),
		.i_wdata(d_wdata),
		.i_commit(d_commit),
		.i_rewind(d_rewind),
		.i_pop(d_pop),
		.o_rdata(d_rdata),
		.o_empty(d_empty),
		.o_used(d_used),
		.o_avail(d_avail)
	);

	// Status FIFO never sees the skip logic
	rsq_fifo #(.W(32), .AW(STS_AW)) u_sfifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_flush(flush_go), // RULE_07
		.i_push(s_push),
		.i_wdata(sts_word_reg),
		.i_commit(s_push),
		.i_rewind(1'b0),
		.i_pop(s_pop), // RULE_05
		.o_rdata(s_rdata),
		.o_empty(s_empty),
		.o_used(s_used),
		.o_avail(s_avail)
	);

	assign o_awready = awready_reg;
	assign o_wready = wready_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_arready = arready_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;
	assign o_mac_ready = mac_ready_reg;
	assign o_rx_enable = receiver_enable_bit_reg;
	assign o_receiver_halted_event = halt_evt_reg;
	assign o_receiver_error_flag = rxe_reg;
endmodule
`default_nettype wire

// >>> hdl/rsq_regs.svh
// Functional notes
// RULE_01: Host pops status, then reads whole packet
// RULE_02: Skip request discards head packet data
// RULE_03: Skip only packets of four words+
// RULE_04: No data reads until skip clears
// RULE_05: Skip leaves status FIFO untouched
// RULE_06: Skip works while receiver runs
// RULE_07: Flush resets both FIFO pointer pairs
// RULE_08: Host halts receiver before flush
// RULE_09: Flush bit self-clears when done
// RULE_10: Checksum word follows payload when enabled
// RULE_11: Status bits 31,14,9:8 read zero
// RULE_12: Bit 30 flags address filter fail
// RULE_13: Bits 29:16 hold frame byte length
// RULE_14: Bit 15 ORs bits 11,7,6,1
// RULE_15: Bit 13 flags broadcast destination
// RULE_16: Bit 12 flags length field mismatch
// RULE_17: Bit 11 runt; dropped unless pass-bad
// RULE_18: Bit 10 flags multicast destination
// RULE_19: Bit 7 flags over 1518, untruncated
// RULE_20: Start offset 0-31 bytes per packet
// RULE_21: Underrun or overrun raises receiver error
// RULE_22: Halt pulses receiver halted event
// RULE_23: Skip bit clears at next packet
// RULE_24: Flush ignored while receiver runs
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH
`define RSQ_A_DATA 8'h00
`define RSQ_A_STS 8'h04
`define RSQ_A_DPCTL 8'h08
`define RSQ_A_CFG 8'h0c
`define RSQ_A_COE 8'h10
`define RSQ_A_MAC 8'h14
`define RSQ_A_INFO 8'h18
`define RSQ_A_FLAG 8'h1c
`define RSQ_B_SKIP 31
`define RSQ_B_FLUSH 15
`define RSQ_F_OFS 12:8
`define RSQ_B_OFS 8
`define RSQ_B_CSUM 0
`define RSQ_B_RECEIVER_ENABLE_BIT 2
`define RSQ_B_PASSBAD 16
`define RSQ_B_RXE 0
`define RSQ_B_HALTED 1
`define RSQ_MAX_FRAME 14'h05ee
`define RSQ_MIN_FRAME 14'h0040
`define RSQ_RESP_OK 2'h0
`define RSQ_RESP_ERR 2'h2
`endif

// >>> hdl/rsq_pkg.sv
package rsq_pkg;
	typedef enum logic [2:0] {
		WS_IDLE, WS_PAD, WS_DATA, WS_CSUM, WS_TAIL, WS_STS
	} rsq_wstate_t;
	typedef logic [31:0] rsq_word_t;
endpackage

// >>> hdl/rsq_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module rsq_fifo #(
	parameter int W = 32,
	parameter int AW = 5
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_push,
	input wire logic [W-1:0] i_wdata,
	input wire logic i_commit,
	input wire logic i_rewind,
	input wire logic i_pop,
	output logic [W-1:0] o_rdata,
	output logic o_empty,
	output logic [AW:0] o_used,
	output logic [AW:0] o_avail
);
	logic [W-1:0] mem_reg [2**AW];
	logic [AW:0] wr_reg, cm_reg, rd_reg;
	logic [AW:0] wr_next;
	assign wr_next = i_push ? wr_reg + 1'b1 : wr_reg;
	assign o_rdata = mem_reg[rd_reg[AW-1:0]];
	assign o_empty = (rd_reg == cm_reg);
	assign o_used = wr_reg - rd_reg;
	assign o_avail = cm_reg - rd_reg;
	always_ff @(posedge i_clk) begin
		if (i_push)
			mem_reg[wr_reg[AW-1:0]] <= i_wdata;
	end
	// Uncommitted words stay invisible to the reader
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_reg <= '0;
			cm_reg <= '0;
			rd_reg <= '0;
		end else if (i_flush) begin
			wr_reg <= '0; // RULE_07
			cm_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= i_rewind ? cm_reg : wr_next;
			if (i_commit)
				cm_reg <= wr_next;
			if (i_pop && !o_empty)
				rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/rsq_sts_pack.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_sts_pack (
	input wire logic [13:0] i_len,
	input wire logic i_filter_fail,
	input wire logic i_bcast,
	input wire logic i_mcast,
	input wire logic i_len_err,
	input wire logic [6:0] i_low,
	output logic [31:0] o_word
);
	logic runt, too_long;
	assign runt = (i_len < `RSQ_MIN_FRAME); // RULE_17
	assign too_long = (i_len > `RSQ_MAX_FRAME); // RULE_19
	always_comb begin
		o_word = '0; // RULE_11
		o_word[30] = i_filter_fail; // RULE_12
		o_word[29:16] = i_len; // RULE_13
		o_word[15] = runt | too_long | i_low[6] | i_low[1]; // RULE_14
		o_word[13] = i_bcast; // RULE_15
		o_word[12] = i_len_err; // RULE_16
		o_word[11] = runt; // RULE_17
		o_word[10] = i_mcast; // RULE_18
		o_word[7] = too_long; // RULE_19
		o_word[6:0] = i_low;
	end
endmodule
`default_nettype wire

// >>> verification/rsq_rx_fifo_host_readout_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_rx_fifo_host_readout_asserts (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic i_awvalid,
	input wire logic i_wvalid,
	input wire logic o_bvalid,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_rx_enable,
	input wire logic o_receiver_halted_event,
	input wire logic o_receiver_error_flag
);
	logic [7:0] ra_reg;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ra_reg <= 8'hff;
		end else if (i_arvalid && o_arready) begin
			ra_reg <= i_araddr;
		end
	end
	wire logic sts_rd = o_rvalid && ra_reg == `RSQ_A_STS;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	property p_halt_pulse;
		o_receiver_halted_event |=> !o_receiver_halted_event;
	endproperty
	a_halt_pulse: assert property (p_halt_pulse) else $error("halt event too long");
	property p_halt_off;
		$rose(o_receiver_halted_event) |-> !o_rx_enable;
	endproperty
	a_halt_off: assert property (p_halt_off) else $error("halt event while enabled");
	property p_err_sticky;
		o_receiver_error_flag && !i_awvalid && !i_wvalid && !$past(i_awvalid) && !$past(i_wvalid)
			&& !o_bvalid |=> o_receiver_error_flag;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");
	property p_sts_rsvd;
		sts_rd |-> o_rdata[31] == 1'b0 && o_rdata[14] == 1'b0 && o_rdata[9:8] == 2'h0;
	endproperty
	a_sts_rsvd: assert property (p_sts_rsvd) else $error("status reserved bit set");
	property p_es;
		sts_rd |-> o_rdata[15] == (o_rdata[11] | o_rdata[7] | o_rdata[6] | o_rdata[1]);
	endproperty
	a_es: assert property (p_es) else $error("error summary wrong");
	property p_long;
		sts_rd |-> o_rdata[7] == (o_rdata[29:16] > `RSQ_MAX_FRAME);
	endproperty
	a_long: assert property (p_long) else $error("too long flag wrong");
	property p_runt;
		sts_rd && o_rdata != 32'h0 |-> o_rdata[11] == (o_rdata[29:16] < `RSQ_MIN_FRAME);
	endproperty
	a_runt: assert property (p_runt) else $error("runt flag wrong");
	property p_flush_clr;
		o_rvalid && ra_reg == `RSQ_A_CFG |-> !o_rdata[`RSQ_B_FLUSH];
	endproperty
	a_flush_clr: assert property (p_flush_clr) else $error("flush bit stuck");
	c_halt: cover property (o_receiver_halted_event);
	c_long: cover property (sts_rd && o_rdata[7]);
	c_err: cover property ($rose(o_receiver_error_flag));
endmodule
bind rsq_rx_fifo_host_readout rsq_rx_fifo_host_readout_asserts i_rsq_rx_fifo_host_readout_asserts (
	.i_clk, .i_rst_n, .i_araddr, .i_arvalid, .o_arready, .i_awvalid, .i_wvalid, .o_bvalid,
	.o_rdata, .o_rvalid, .o_rx_enable, .o_receiver_halted_event, .o_receiver_error_flag);
`default_nettype wire

// >>> verification/rsq_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
module rsq_mac_model (
	input wire logic i_clk,
	input wire logic i_ready,
	output logic o_valid,
	output logic o_last,
	output logic o_busy,
	output logic [31:0] o_data,
	output logic [31:0] o_csum,
	output logic [13:0] o_len,
	output logic [10:0] o_fl
);
	initial begin
		o_valid = 1'b0;
		o_last = 1'b0;
		o_busy = 1'b0;
		o_data = 32'h0;
		o_csum = 32'h0;
		o_len = 14'h0;
		o_fl = 11'h0;
	end
	// Four-word frame, optional idle cycle after each word
	task automatic send(input logic [31:0] d0, input logic [13:0] len, input logic [10:0] fl, input logic gap);
		o_busy <= 1'b1;
		o_len <= len;
		o_fl <= fl;
		o_csum <= ~d0;
		for (int k = 0; k < 4; k++) begin
			o_valid <= 1'b1;
			o_data <= d0 + k;
			o_last <= k == 3;
			do @(posedge i_clk);
			while (!i_ready);
			if (gap) begin
				o_valid <= 1'b0;
				@(posedge i_clk);
			end
		end
		// Released lines show inverted values
		o_valid <= 1'b0;
		o_last <= 1'b0;
		o_busy <= 1'b0;
		o_data <= ~o_data;
		o_csum <= d0;
		o_len <= ~len;
		o_fl <= ~fl;
		@(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// >>> verification/rsq_rx_fifo_host_readout_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_rx_fifo_host_readout_bench import rsq_pkg::*;;
	typedef struct {string n; rsq_word_t e; rsq_word_t m; logic [1:0] r;} rsq_exp_t;
	logic i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata;
	logic [3:0] i_wstrb;
	wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_mac_ready;
	wire logic o_rx_enable, o_receiver_halted_event, o_receiver_error_flag;
	wire logic [1:0] o_bresp, o_rresp;
	wire logic [31:0] o_rdata, i_mac_data, i_mac_csum;
	wire logic i_mac_valid, i_mac_last, i_mac_busy;
	wire logic [13:0] i_mac_len;
	wire logic [10:0] fl;
	rsq_exp_t q[$];
	rsq_exp_t ex;
	rsq_word_t vv, dd, a0, a1;
	logic [10:0] f0, f1;
	logic [13:0] ls [4] = '{14'h003f, 14'h0040, 14'h05ee, 14'h05ef};
	logic [31:0] rs = 32'h97772771;
	int fails = 0;
	int compares = 0;
	rsq_rx_fifo_host_readout i_rsq_rx_fifo_host_readout (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
		.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_mac_valid,
		.o_mac_ready, .i_mac_data, .i_mac_last, .i_mac_busy, .i_mac_csum, .i_mac_len,
		.i_mac_filter_fail(fl[10]), .i_mac_bcast(fl[9]), .i_mac_mcast(fl[8]), .i_mac_len_err(fl[7]),
		.i_mac_low(fl[6:0]), .o_rx_enable, .o_receiver_halted_event, .o_receiver_error_flag);
	rsq_mac_model i_rsq_mac_model (.i_clk, .i_ready(o_mac_ready), .o_valid(i_mac_valid),
		.o_last(i_mac_last), .o_busy(i_mac_busy), .o_data(i_mac_data), .o_csum(i_mac_csum),
		.o_len(i_mac_len), .o_fl(fl));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	function automatic void nx();
		rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
	endfunction
	function automatic rsq_word_t sw(input logic [13:0] l, input logic [10:0] f);
		logic ru, tl;
		ru = l < `RSQ_MIN_FRAME;
		tl = l > `RSQ_MAX_FRAME;
		return {1'b0, f[10], l, ru | tl | f[6] | f[1], 1'b0, f[9], f[7], ru, f[8], 2'h0, tl, f[6:0]};
	endfunction
	task close_out();
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input rsq_word_t d, input logic [1:0] r);
		q.push_back('{"bresp", {30'h0, r}, 32'h3, r});
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while (!o_bvalid);
		i_bready <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input rsq_word_t e, m, input string n, output rsq_word_t d);
		q.push_back('{n, e, m, (a[1:0] != 2'h0 || a > `RSQ_A_FLAG) ? `RSQ_RESP_ERR : `RSQ_RESP_OK});
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		d = o_rdata;
		i_rready <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wt(input logic [7:0] a, input rsq_word_t m, v);
		rsq_word_t d;
		do rd(a, 32'h0, 32'h0, "poll", d);
		while ((d & m) != v);
	endtask
	task automatic snd(input logic [13:0] l, output rsq_word_t d0, output logic [10:0] f);
		nx();
		d0 = rs;
		nx();
		f = rs[10:0] & 11'h7fe;
		i_rsq_mac_model.send(d0, l, f, rs[11]);
	endtask
	task automatic drn(input logic [13:0] l, input rsq_word_t d0, input logic [10:0] f, input logic cs);
		rd(`RSQ_A_STS, sw(l, f), '1, "status", dd);
		for (int k = 0; k < 4; k++) rd(`RSQ_A_DATA, d0 + k, '1, "data", dd);
		if (cs) rd(`RSQ_A_DATA, ~d0, '1, "csum", dd);
	endtask
	always @(posedge i_clk) begin
		if ((o_rvalid && i_rready) || (o_bvalid && i_bready)) begin
			ex = q.pop_front();
			vv = (o_rvalid && i_rready) ? o_rdata : {30'h0, o_bresp};
			compares++;
			if ((vv & ex.m) !== (ex.e & ex.m)) begin
				$display("BAD %s exp %h got %h", ex.n, ex.e, vv);
				fails++;
			end
			if (o_rvalid && i_rready && o_rresp !== ex.r) begin
				$display("BAD rresp exp %h got %h", ex.r, o_rresp);
				fails++;
			end
		end
	end
	initial begin
		#1000000;
		fails++;
		close_out();
	end
	initial begin
		{i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h0;
		{i_awaddr, i_araddr, i_wdata} = 48'h0;
		i_wstrb = 4'hf;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		wr(`RSQ_A_MAC, 32'h00010004, `RSQ_RESP_OK);
		wr(`RSQ_A_COE, 32'h1, `RSQ_RESP_OK);
		for (int i = 0; i < 4; i++) begin
			snd(ls[i], a0, f0);
			wt(`RSQ_A_INFO, 32'hff0000, 32'h10000);
			drn(ls[i], a0, f0, 1'b1);
		end
		snd(14'h0100, a0, f0);
		snd(14'h0100, a1, f1);
		wt(`RSQ_A_INFO, 32'hff0000, 32'h20000);
		rd(`RSQ_A_INFO, 32'h0002000a, '1, "info", dd);
		wr(`RSQ_A_DPCTL, 32'h80000000, `RSQ_RESP_OK);
		wt(`RSQ_A_DPCTL, 32'h80000000, 32'h0);
		rd(`RSQ_A_INFO, 32'h00020005, '1, "skip info", dd);
		rd(`RSQ_A_STS, sw(14'h0100, f0), '1, "skip status", dd);
		drn(14'h0100, a1, f1, 1'b1);
		wr(`RSQ_A_COE, 32'h0, `RSQ_RESP_OK);
		wr(`RSQ_A_CFG, 32'h500, `RSQ_RESP_OK);
		snd(14'h0100, a0, f0);
		wt(`RSQ_A_INFO, 32'hff0000, 32'h10000);
		rd(`RSQ_A_STS, sw(14'h0100, f0), '1, "status", dd);
		rd(`RSQ_A_DATA, 32'h0, '1, "pad", dd);
		for (int k = 0; k < 5; k++)
			rd(`RSQ_A_DATA, {24'(a0 + k), 8'((a0 + k - 1) >> 24)},
				k == 0 ? 32'hffffff00 : k == 4 ? 32'hff : '1, "ofs", dd);
		wr(`RSQ_A_CFG, 32'h0, `RSQ_RESP_OK);
		wr(`RSQ_A_MAC, 32'h4, `RSQ_RESP_OK);
		snd(14'h003f, a0, f0);
		snd(14'h0100, a1, f1);
		wt(`RSQ_A_INFO, 32'hff0000, 32'h10000);
		rd(`RSQ_A_INFO, 32'h00010004, '1, "runt drop", dd);
		drn(14'h0100, a1, f1, 1'b0);
		snd(14'h0100, a0, f0);
		wt(`RSQ_A_INFO, 32'hff0000, 32'h10000);
		wr(`RSQ_A_CFG, 32'h8000, `RSQ_RESP_OK);
		rd(`RSQ_A_INFO, 32'h00010004, '1, "flush run", dd);
		wr(`RSQ_A_MAC, 32'h0, `RSQ_RESP_OK);
		wt(`RSQ_A_FLAG, 32'h2, 32'h2);
		wr(`RSQ_A_CFG, 32'h8000, `RSQ_RESP_OK);
		rd(`RSQ_A_CFG, 32'h0, 32'h8000, "flush bit", dd);
		rd(`RSQ_A_INFO, 32'h0, '1, "flush info", dd);
		rd(`RSQ_A_DATA, 32'h0, '1, "under data", dd);
		rd(`RSQ_A_STS, 32'h0, '1, "under status", dd);
		rd(`RSQ_A_FLAG, 32'h1, 32'h1, "error", dd);
		wr(`RSQ_A_FLAG, 32'h1, `RSQ_RESP_OK);
		rd(`RSQ_A_FLAG, 32'h0, 32'h1, "error clr", dd);
		i_wstrb <= 4'h1;
		wr(`RSQ_A_CFG, 32'h1f00, `RSQ_RESP_OK);
		i_wstrb <= 4'hf;
		rd(`RSQ_A_CFG, 32'h0, 32'h1f00, "strobe", dd);
		wr(8'hfc, 32'h0, `RSQ_RESP_ERR);
		rd(8'hfc, 32'h0, '1, "unmapped", dd);
		close_out();
	end
endmodule
`default_nettype wire
